// *** hw/flash_wp_pkg.sv ***
package flash_wp_pkg;
  // Command opcodes
  localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_PAGE_PROG      = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG_A    = 8'h32;
  localparam logic [7:0] CMD_QUAD_PROG_B    = 8'h38;
  localparam logic [7:0] CMD_SECTOR_ERASE_A = 8'hd7;
  localparam logic [7:0] CMD_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] CMD_HALF_BLK_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE    = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A   = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERASE_B   = 8'h60;
  localparam logic [7:0] CMD_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] CMD_FUNC_WRITE     = 8'h42;
  localparam logic [7:0] CMD_NV_READ_SET    = 8'h65;
  localparam logic [7:0] CMD_NV_EXT_SET     = 8'h85;
  localparam logic [7:0] CMD_INFO_ERASE     = 8'h64;
  localparam logic [7:0] CMD_INFO_PROG      = 8'h62;
  localparam logic [7:0] CMD_BOOT_WRITE     = 8'h15;
  localparam logic [7:0] CMD_V_READ_SET_A   = 8'hc0;
  localparam logic [7:0] CMD_V_READ_SET_B   = 8'h63;
  localparam logic [7:0] CMD_V_EXT_SET      = 8'h83;
  localparam logic [7:0] CMD_STATUS_READ    = 8'h05;
  localparam logic [7:0] CMD_FUNC_READ      = 8'h48;
  localparam logic [7:0] CMD_EXT_READ       = 8'h81;
  localparam logic [7:0] CMD_RESET_ENABLE   = 8'h66;
  localparam logic [7:0] CMD_RESET          = 8'h99;
  localparam logic [7:0] CMD_SUSPEND_A      = 8'h75;
  localparam logic [7:0] CMD_SUSPEND_B      = 8'hb0;
  localparam logic [7:0] CMD_RESUME_A       = 8'h7a;
  localparam logic [7:0] CMD_RESUME_B       = 8'h30;
  // Status register fields
  localparam int         ST_WIP  = 0;
  localparam int         ST_WEL  = 1;
  localparam int         ST_BP_LO = 2;
  localparam int         ST_QE   = 6;
  localparam int         ST_STATUS_WRITE_DISABLE = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STATUS_NV_MASK = 8'hfc;
  // Function register fields
  localparam int         FN_RST_DIS = 0;
  localparam int         FN_PROGRAM_SUSPENDED    = 2;
  localparam int         FN_ERASE_SUSPENDED    = 3;
  localparam int         FN_IRL_LO  = 4;
  localparam logic [7:0] FUNC_OTP_MASK = 8'hf1;
  // Array geometry: 64KB blocks, 24-bit address
  localparam int         ADDR_W    = 24;
  localparam int         BLOCK_MSB = 20;
  localparam int         BLOCK_LSB = 16;
  localparam int         NUM_BLOCKS = 32;
  localparam int         IROW_SEL_LSB = 12;
  // Frame shape: opcode, then up to three address bytes or one data byte
  localparam int         BITS_PER_BYTE = 8;
  localparam int         MAX_FRAME_BITS = 32;

  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE, OP_REG} op_kind_t;
endpackage

// *** hw/protect_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module protect_decode
  import flash_wp_pkg::*;
(
  // Protection code and target block
  input  wire logic [3:0] i_code,
  input  wire logic [4:0] i_block,
  // Result
  output logic            o_protected
);
  always_comb begin
    case (i_code)
      4'h0, 4'hf: o_protected = 1'b0;
      4'h1:       o_protected = (i_block == 5'h1f);
      4'h2:       o_protected = (i_block >= 5'h1e);
      4'h3:       o_protected = (i_block >= 5'h1c);
      4'h4:       o_protected = (i_block >= 5'h18);
      4'h5:       o_protected = (i_block >= 5'h10);
      4'ha:       o_protected = (i_block <= 5'h0f);
      4'hb:       o_protected = (i_block <= 5'h07);
      4'hc:       o_protected = (i_block <= 5'h03);
      4'hd:       o_protected = (i_block <= 5'h01);
      4'he:       o_protected = (i_block == 5'h00);
      default:    o_protected = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// *** hw/flash_write_protect_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_write_protect_status_regs
  import flash_wp_pkg::*;
#(
  parameter logic RST_DIS_DEFAULT = 1'b0
) (
  // Clock, reset, enable
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_enable,
  // Serial link pins (async to i_clock)
  input  wire logic              i_chip_enable_n,
  input  wire logic              i_serial_clock,
  input  wire logic              i_serial_in,
  input  wire logic              i_write_protect_n,
  // Operation engine handshake (same clock)
  input  wire logic              i_op_done,
  input  wire logic              i_op_suspended,
  input  wire logic              i_op_resumed,
  // Operation launch
  output logic                   o_op_start,
  output op_kind_t               o_op_kind,
  output logic [ADDR_W-1:0]      o_op_addr,
  output logic [7:0]             o_op_cmd,
  // Register views and pin function
  output logic [7:0]             o_status,
  output logic [7:0]             o_function,
  output logic                   o_quad_mode,
  output logic                   o_hold_reset_shared
);
  // Frame decode and block decode are written for this geometry only
  if (NUM_BLOCKS != 32 || MAX_FRAME_BITS != 32 || ADDR_W != 24) begin : g_bad_geometry
    $error("frame or block geometry not served");
  end

  // Pin synchronisers
  logic [1:0] ce_s_r, sck_s_r, si_s_r, wp_s_r;
  logic       sck_d_r;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ce_s_r  <= 2'h3;
      sck_s_r <= 2'h0;
      si_s_r  <= 2'h0;
      wp_s_r  <= 2'h3;
      sck_d_r <= 1'b0;
    end else if (i_enable) begin
      ce_s_r  <= {ce_s_r[0], i_chip_enable_n};
      sck_s_r <= {sck_s_r[0], i_serial_clock};
      si_s_r  <= {si_s_r[0], i_serial_in};
      wp_s_r  <= {wp_s_r[0], i_write_protect_n};
      sck_d_r <= sck_s_r[1];
    end
  end
  logic ce_n, sck_rise, si, wp_n;
  assign ce_n     = ce_s_r[1];
  assign si       = si_s_r[1];
  assign wp_n     = wp_s_r[1];
  assign sck_rise = sck_s_r[1] & ~sck_d_r & ~ce_n;

  // Frame shifter: last 32 bits of a frame kept, acted on at chip-enable rise
  logic [MAX_FRAME_BITS-1:0] shift_r;
  logic [5:0]                nbits_r;
  logic                      ce_n_d_r;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      shift_r  <= '0;
      nbits_r  <= 6'h00;
      ce_n_d_r <= 1'b1;
    end else if (i_enable) begin
      ce_n_d_r <= ce_n;
      if (ce_n) begin
        nbits_r <= 6'h00;
      end else if (sck_rise) begin
        shift_r <= {shift_r[MAX_FRAME_BITS-2:0], si};
        if (nbits_r != 6'h3f) nbits_r <= nbits_r + 6'h01;
      end
    end
  end
  logic frame_end;
  assign frame_end = ce_n & ~ce_n_d_r;

  // Frame decode
  logic [7:0]        cmd;
  logic [7:0]        data_byte;
  logic [ADDR_W-1:0] addr;
  logic              has_addr;
  logic              has_data;
  always_comb begin
    cmd       = 8'h00;
    data_byte = 8'h00;
    addr      = '0;
    has_addr  = 1'b0;
    has_data  = 1'b0;
    if (nbits_r >= 6'd32) begin
      cmd      = shift_r[31:24];
      addr     = shift_r[23:0];
      has_addr = 1'b1;
    end else if (nbits_r >= 6'd16) begin
      cmd       = shift_r[15:8];
      data_byte = shift_r[7:0];
      has_data  = 1'b1;
    end else if (nbits_r >= 6'd8) begin
      cmd = shift_r[7:0];
    end
  end

  function automatic logic is_prog(input logic [7:0] c);
    return c == CMD_PAGE_PROG || c == CMD_QUAD_PROG_A || c == CMD_QUAD_PROG_B;
  endfunction
  function automatic logic is_erase(input logic [7:0] c);
    return c == CMD_SECTOR_ERASE_A || c == CMD_SECTOR_ERASE_B || c == CMD_HALF_BLK_ERASE ||
           c == CMD_BLOCK_ERASE;
  endfunction
  function automatic logic is_chip_erase(input logic [7:0] c);
    return c == CMD_CHIP_ERASE_A || c == CMD_CHIP_ERASE_B;
  endfunction
  function automatic logic is_nv_reg(input logic [7:0] c);
    return c == CMD_STATUS_WRITE || c == CMD_FUNC_WRITE || c == CMD_NV_READ_SET ||
           c == CMD_NV_EXT_SET || c == CMD_BOOT_WRITE;
  endfunction
  function automatic logic is_busy_ok(input logic [7:0] c);
    return c == CMD_STATUS_READ || c == CMD_FUNC_READ || c == CMD_EXT_READ ||
           c == CMD_RESET_ENABLE || c == CMD_RESET || c == CMD_SUSPEND_A || c == CMD_SUSPEND_B;
  endfunction

  // Registers
  logic       wel_r, wip_r;
  logic [3:0] bp_r;
  logic       qe_r, status_write_disable_r;
  logic       rst_dis_r, program_suspended_r, erase_suspended_r;
  logic [3:0] irl_r;
  logic       rst_dis_loaded_r;
  op_kind_t   running_r;

  logic [3:0] irow_sel;
  logic       blk_prot, bp_zero, hw_locked;
  assign irow_sel  = 4'h1 << addr[IROW_SEL_LSB +: 2];
  assign bp_zero   = (bp_r == 4'h0);
  assign hw_locked = status_write_disable_r & ~wp_n;

  protect_decode u_decode (
    .i_code      (bp_r),
    .i_block     (addr[BLOCK_MSB:BLOCK_LSB]),
    .o_protected (blk_prot)
  );

  // Command acceptance
  logic gated, accept_cmd, go_prog, go_erase, go_reg, go_any, is_ce;
  always_comb begin
    is_ce    = is_chip_erase(cmd);
    gated    = is_prog(cmd) || is_erase(cmd) || is_ce || is_nv_reg(cmd) ||
               cmd == CMD_INFO_PROG || cmd == CMD_INFO_ERASE; // Volatile sets left out
    accept_cmd = frame_end && nbits_r >= 6'd8 && (!wip_r || is_busy_ok(cmd));
    go_prog  = accept_cmd && wel_r && is_prog(cmd) && has_addr && !blk_prot;
    go_prog  = go_prog || (accept_cmd && wel_r && cmd == CMD_INFO_PROG && has_addr &&
               (irow_sel & irl_r) == 4'h0);
    go_erase = accept_cmd && wel_r && ((is_erase(cmd) && has_addr && !blk_prot) ||
               (is_ce && bp_zero) || (cmd == CMD_INFO_ERASE && has_addr));
    go_reg   = accept_cmd && wel_r && has_data && is_nv_reg(cmd) &&
               !(cmd == CMD_STATUS_WRITE && hw_locked);
    go_any   = go_prog || go_erase || go_reg;
  end

  // Write-enable latch
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wel_r <= 1'b0;
    end else if (i_enable) begin
      if (accept_cmd && cmd == CMD_WRITE_ENABLE) begin
        wel_r <= 1'b1;
      end else if (accept_cmd && cmd == CMD_WRITE_DISABLE) begin
        wel_r <= 1'b0;
      end else if (wip_r && i_op_done) begin
        wel_r <= 1'b0;
      end
    end
  end

  // Busy flag and running operation
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wip_r     <= 1'b0;
      running_r <= OP_NONE;
    end else if (i_enable) begin
      if (go_any) begin
        wip_r     <= 1'b1;
        running_r <= go_prog ? OP_PROG : (go_erase ? OP_ERASE : OP_REG);
      end else if (wip_r && (i_op_done || i_op_suspended)) begin
        wip_r     <= 1'b0;
        running_r <= i_op_done ? OP_NONE : running_r;
      end else if (i_op_resumed && (program_suspended_r || erase_suspended_r)) begin
        wip_r <= 1'b1;
      end
    end
  end

  // Status register non-volatile bits
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      {status_write_disable_r, qe_r, bp_r} <= STATUS_RESET[7:2];
    end else if (i_enable && go_reg && cmd == CMD_STATUS_WRITE) begin
      {status_write_disable_r, qe_r, bp_r} <= data_byte[ST_STATUS_WRITE_DISABLE:ST_BP_LO];
    end
  end

  // Function register one-time bits and suspend flags
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rst_dis_loaded_r <= 1'b0;
      rst_dis_r        <= 1'b0;
      irl_r            <= 4'h0;
      program_suspended_r           <= 1'b0;
      erase_suspended_r           <= 1'b0;
    end else if (i_enable) begin
      if (!rst_dis_loaded_r) begin
        rst_dis_loaded_r <= 1'b1;
        rst_dis_r        <= RST_DIS_DEFAULT;
      end else if (go_reg && cmd == CMD_FUNC_WRITE) begin
        rst_dis_r <= rst_dis_r | data_byte[FN_RST_DIS];
      end
      if (go_reg && cmd == CMD_FUNC_WRITE) begin
        irl_r <= irl_r | data_byte[FN_IRL_LO +: 4];
      end
      if (i_op_suspended && running_r == OP_PROG) program_suspended_r <= 1'b1;
      else if (i_op_resumed) program_suspended_r <= 1'b0;
      if (i_op_suspended && running_r == OP_ERASE) erase_suspended_r <= 1'b1;
      else if (i_op_resumed) erase_suspended_r <= 1'b0;
    end
  end

  // Operation launch outputs, registered
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_op_start <= 1'b0;
      o_op_kind  <= OP_NONE;
      o_op_addr  <= '0;
      o_op_cmd   <= 8'h00;
    end else if (i_enable) begin
      o_op_start <= go_any;
      if (go_any) begin
        o_op_kind <= go_prog ? OP_PROG : (go_erase ? OP_ERASE : OP_REG);
        o_op_addr <= addr;
        o_op_cmd  <= cmd;
      end
    end
  end

  assign o_status = {status_write_disable_r, qe_r, bp_r, wel_r, wip_r};
  assign o_function = {irl_r, erase_suspended_r, program_suspended_r, 1'b0, rst_dis_r};
  assign o_quad_mode = qe_r;
  assign o_hold_reset_shared = rst_dis_r & ~qe_r;

  property p_wel_set;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && accept_cmd && cmd == CMD_WRITE_ENABLE) |=> wel_r;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  property p_gate;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && !wel_r) |=> !o_op_start;
  endproperty
  a_gate: assert property (p_gate) else $error("launch without latch");

  property p_wel_clr;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && accept_cmd && cmd == CMD_WRITE_DISABLE) |=> !wel_r;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");

  property p_done_clr;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && wip_r && i_op_done && !accept_cmd) |=> !wel_r && !wip_r;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done left latch");

  property p_prot;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && accept_cmd && is_prog(cmd) && blk_prot) |=> !o_op_start;
  endproperty
  a_prot: assert property (p_prot) else $error("protected program launched");

  property p_ce;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && accept_cmd && is_ce && !bp_zero) |=> !o_op_start && $stable(wel_r);
  endproperty
  a_ce: assert property (p_ce) else $error("chip erase not ignored");

  property p_hw;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && hw_locked) |=> $stable(o_status[7:2]);
  endproperty
  a_hw: assert property (p_hw) else $error("locked status changed");

  property p_otp;
    @(posedge i_clock) disable iff (i_reset)
      rst_dis_loaded_r |=> (irl_r & $past(irl_r)) == $past(irl_r);
  endproperty
  a_otp: assert property (p_otp) else $error("lock bit cleared");

  property p_busy;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && wip_r && frame_end && !is_busy_ok(cmd) && !i_op_done) |=> $stable(wel_r) && !o_op_start;
  endproperty
  a_busy: assert property (p_busy) else $error("busy command acted");

  // A refused gated command may not touch the latch, protection bits or busy flag
  property p_reject;
    @(posedge i_clock) disable iff (i_reset)
      (i_enable && accept_cmd && gated && !go_any && !i_op_resumed) |=> $stable(o_status) && !o_op_start;
  endproperty
  a_reject: assert property (p_reject) else $error("refused command acted");

  c_prog: cover property (@(posedge i_clock) disable iff (i_reset) o_op_start && o_op_kind == OP_PROG);
  c_erase: cover property (@(posedge i_clock) disable iff (i_reset) o_op_start && o_op_kind == OP_ERASE);
  c_program_suspended: cover property (@(posedge i_clock) disable iff (i_reset) program_suspended_r);
  c_lock: cover property (@(posedge i_clock) disable iff (i_reset) hw_locked && frame_end);
endmodule
`default_nettype wire

// *** verif/host_link_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_link_model #(
  parameter int HALF_NS = 80
) (
  // Link pins toward the device
  output logic o_chip_enable_n,
  output logic o_serial_clock,
  output logic o_serial_in
);
  initial begin
    o_chip_enable_n = 1'b1;
    o_serial_clock  = 1'b0;
    o_serial_in     = 1'b0;
  end

  // Mode 0: clock parked low between frames, data changes while it is low
  task automatic send_frame(input logic [31:0] bits, input int nbits);
    o_chip_enable_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_serial_in = bits[31-i];
      #HALF_NS;
      o_serial_clock = 1'b1;
      #HALF_NS;
      o_serial_clock = 1'b0;
    end
    #HALF_NS;
    o_chip_enable_n = 1'b1;
    // Released data line must not look like valid data
    o_serial_in = ~o_serial_in;
    #HALF_NS;
  endtask
endmodule
`default_nettype wire

// *** verif/flash_write_protect_status_regs_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_write_protect_status_regs_bench;
  import flash_wp_pkg::*;
  logic              i_clock;
  logic              i_reset;
  logic              enable;
  logic              write_protect_n;
  logic              op_done;
  logic              op_suspended;
  logic              op_resumed;
  wire logic         chip_enable_n;
  wire logic         serial_clock;
  wire logic         serial_in;
  logic              o_op_start;
  op_kind_t          o_op_kind;
  logic [ADDR_W-1:0] o_op_addr;
  logic [7:0]        o_op_cmd;
  logic [7:0]        o_status;
  logic [7:0]        o_function;
  logic              o_quad_mode;
  logic              o_hold_reset_shared;
  int                num_errors;
  int                check_count;
  int                starts;
  logic [7:0]        gated [16] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7,
                                    8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
  int                probes [10] = '{0, 1, 3, 7, 15, 16, 24, 28, 30, 31};

  host_link_model i_host (
    .o_chip_enable_n (chip_enable_n),
    .o_serial_clock  (serial_clock),
    .o_serial_in     (serial_in)
  );

  flash_write_protect_status_regs i_dut (
    .i_clock             (i_clock),
    .i_reset             (i_reset),
    .i_enable            (enable),
    .i_chip_enable_n     (chip_enable_n),
    .i_serial_clock      (serial_clock),
    .i_serial_in         (serial_in),
    .i_write_protect_n   (write_protect_n),
    .i_op_done           (op_done),
    .i_op_suspended      (op_suspended),
    .i_op_resumed        (op_resumed),
    .o_op_start          (o_op_start),
    .o_op_kind           (o_op_kind),
    .o_op_addr           (o_op_addr),
    .o_op_cmd            (o_op_cmd),
    .o_status            (o_status),
    .o_function          (o_function),
    .o_quad_mode         (o_quad_mode),
    .o_hold_reset_shared (o_hold_reset_shared)
  );

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    if (o_op_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Engine pulses: 0 done, 1 suspended, 2 resumed
  task automatic pulse(input int which);
    @(posedge i_clock);
    #1;
    op_done      = (which == 0);
    op_suspended = (which == 1);
    op_resumed   = (which == 2);
    @(posedge i_clock);
    #1;
    {op_done, op_suspended, op_resumed} = 3'b000;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  // Sends one frame, checks the launch count; the engine finishes a launch if asked
  task automatic xfer(input logic [31:0] bits, input int nbits, input int exp_start, input bit finish);
    int n0;
    n0 = starts;
    i_host.send_frame(bits, nbits);
    repeat (8) @(posedge i_clock);
    #1;
    check8(8'(starts - n0), 8'(exp_start));
    if (finish && starts != n0) begin
      pulse(0);
    end
  endtask

  task automatic write_enable_cmd();
    xfer({CMD_WRITE_ENABLE, 24'h0}, 8, 0, 0);
  endtask

  task automatic wsr(input logic [7:0] d, input int exp_start);
    write_enable_cmd();
    xfer({CMD_STATUS_WRITE, d, 16'h0}, 16, exp_start, 1);
  endtask

  function automatic bit prot(input int c, input int b);
    if (c == 0 || c == 15) return 1'b0;
    if (c >= 6 && c <= 9) return 1'b1;
    if (c <= 5) return b >= 32 - (1 << (c - 1));
    return b < (1 << (14 - c));
  endfunction

  initial begin
    #1_800_000;
    num_errors++;
    wrap_up();
  end

  initial begin
    i_reset = 1'b1;
    write_protect_n = 1'b1;
    enable = 1'b1;
    {op_done, op_suspended, op_resumed} = 3'b000;
    num_errors = 0;
    check_count = 0;
    starts = 0;
    repeat (10) @(posedge i_clock);
    #1;
    i_reset = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    check8(o_status, STATUS_RESET);
    check8(o_function, 8'h00);
    // A frozen block must not see a whole frame go by
    enable = 1'b0;
    write_enable_cmd();
    check8(o_status, 8'h00);
    enable = 1'b1;
    foreach (gated[i]) xfer({gated[i], 24'h0}, 32, 0, 1);
    check8(o_status, 8'h00);
    xfer({CMD_V_READ_SET_A, 8'h00, 16'h0}, 16, 0, 0);
    check8(o_status, 8'h00);
    write_enable_cmd();
    check8(o_status, 8'h02);
    xfer({CMD_WRITE_DISABLE, 24'h0}, 8, 0, 0);
    check8(o_status, 8'h00);
    write_enable_cmd();
    xfer({CMD_PAGE_PROG, 24'h012345}, 32, 1, 0);
    check8({6'h0, o_op_kind}, {6'h0, OP_PROG});
    check8(o_op_addr[23:16], 8'h01);
    check8(o_op_addr[7:0], 8'h45);
    check8(o_op_cmd, CMD_PAGE_PROG);
    check8(o_status, 8'h03);
    xfer({CMD_WRITE_DISABLE, 24'h0}, 8, 0, 0);
    check8(o_status, 8'h03);
    pulse(0);
    check8(o_status, 8'h00);
    write_enable_cmd();
    xfer({CMD_PAGE_PROG, 24'h000100}, 32, 1, 0);
    pulse(1);
    check8(o_function, 8'h04);
    pulse(2);
    check8(o_function, 8'h00);
    pulse(0);
    write_enable_cmd();
    xfer({CMD_SECTOR_ERASE_A, 24'h001000}, 32, 1, 0);
    check8({6'h0, o_op_kind}, {6'h0, OP_ERASE});
    pulse(1);
    check8(o_function, 8'h08);
    pulse(2);
    check8(o_function, 8'h00);
    pulse(0);
    check8(o_status, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wsr({2'b00, 4'(c), 2'b00}, 1);
      check8(o_status, {2'b00, 4'(c), 2'b00});
      foreach (probes[p]) begin
        write_enable_cmd();
        xfer({CMD_BLOCK_ERASE, 3'b000, 5'(probes[p]), 16'h0}, 32, int'(!prot(c, probes[p])), 1);
      end
      write_enable_cmd();
      xfer({(c % 2 == 1) ? CMD_CHIP_ERASE_B : CMD_CHIP_ERASE_A, 24'h0}, 8, int'(c == 0), 1);
    end
    wsr(8'h80, 1);
    check8(o_status, 8'h80);
    check8({6'h0, o_op_kind}, {6'h0, OP_REG});
    check8(o_op_cmd, CMD_STATUS_WRITE);
    write_protect_n = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    wsr(8'h00, 0);
    check8(o_status & STATUS_NV_MASK, 8'h80);
    write_protect_n = 1'b1;
    repeat (4) @(posedge i_clock);
    #1;
    wsr(8'h40, 1);
    check8({7'h0, o_quad_mode}, 8'h01);
    write_enable_cmd();
    xfer({CMD_FUNC_WRITE, 8'h13, 16'h0}, 16, 1, 1);
    check8(o_function, 8'h11);
    check8({7'h0, o_hold_reset_shared}, 8'h00);
    wsr(8'h00, 1);
    check8({7'h0, o_hold_reset_shared}, 8'h01);
    write_enable_cmd();
    xfer({CMD_FUNC_WRITE, 8'h00, 16'h0}, 16, 1, 1);
    check8(o_function, 8'h11);
    write_enable_cmd();
    xfer({CMD_INFO_PROG, 24'h000000}, 32, 0, 1);
    write_enable_cmd();
    xfer({CMD_INFO_PROG, 24'h001000}, 32, 1, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
